// ---- src/supervisor_pkg.sv ----
// Purpose: Shared constants and types for the supply supervisor
// Assumes: 125 MHz timebase
// Notes:   Times are kept in their printed unit, cycle counts derived
package supervisor_pkg;

  localparam int unsigned CLK_MHZ = 125;

  // ------------------------------------------------------------
  // Reset hold times, microseconds
  // ------------------------------------------------------------
  localparam int unsigned HOLD_US_0 = 1400;
  localparam int unsigned HOLD_US_1 = 28000;
  localparam int unsigned HOLD_US_2 = 200000;
  localparam int unsigned HOLD_US_3 = 1600000;

  // ------------------------------------------------------------
  // Watchdog periods, microseconds
  // ------------------------------------------------------------
  localparam int unsigned WDOG_US_0 = 6200;
  localparam int unsigned WDOG_US_1 = 102000;
  localparam int unsigned WDOG_US_2 = 1600000;
  localparam int unsigned WDOG_US_3 = 25600000;

  // ------------------------------------------------------------
  // Manual reset timing, nanoseconds
  // ------------------------------------------------------------
  localparam int unsigned MANUAL_MIN_NS   = 25000;
  localparam int unsigned MANUAL_DELAY_NS = 12000;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned MANUAL_FILT_CYC = (MANUAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MANUAL_DLY_CYC  = MANUAL_DELAY_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int unsigned CNT_W         = 32;
  localparam logic [1:0]  SEL_RESET     = 2'h0;
  localparam logic        FLAG_IDLE     = 1'b1;

  function automatic logic [CNT_W-1:0] hold_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    hold_cycles = CNT_W'(HOLD_US_0 * CLK_MHZ);
      2'h1:    hold_cycles = CNT_W'(HOLD_US_1 * CLK_MHZ);
      2'h2:    hold_cycles = CNT_W'(HOLD_US_2 * CLK_MHZ);
      default: hold_cycles = CNT_W'(HOLD_US_3 * CLK_MHZ);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] wdog_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    wdog_cycles = CNT_W'(64'(WDOG_US_0) * CLK_MHZ);
      2'h1:    wdog_cycles = CNT_W'(64'(WDOG_US_1) * CLK_MHZ);
      2'h2:    wdog_cycles = CNT_W'(64'(WDOG_US_2) * CLK_MHZ);
      default: wdog_cycles = CNT_W'(64'(WDOG_US_3) * CLK_MHZ);
    endcase
  endfunction

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_RUN   = 2'b01
  } sup_state_t;

  // Raw condition pins, all asynchronous to clk_i
  typedef struct packed {
    logic supply_low;
    logic manual_reset_n;
    logic aux_sense_in;
    logic low_line;
    logic watchdog_kick;
  } sense_t;

endpackage

// ---- src/sync2.sv ----
// Purpose: Two-stage synchroniser for one level
// Assumes: Input asynchronous to clk_i
// Notes:   First stage read only by the second
`timescale 1ns/10ps
module sync2
  import supervisor_pkg::*;
#(
  parameter logic INIT = 1'b0
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  // Level
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_st_t;

  sync_st_t st;
  sync_st_t next_st;

  always_comb
  begin
    next_st    = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st <= {INIT, INIT};
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;

endmodule

// ---- src/manual_debounce.sv ----
// Purpose: Debounce of the manual reset input
// Assumes: Input already synchronised
// Notes:   Low must persist the minimum width, then a further delay
`timescale 1ns/10ps
module manual_debounce
  import supervisor_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  // Level in, qualified request out
  input  wire logic manual_reset_n_i,
  output logic      manual_active_o
);

  localparam logic [CNT_W-1:0] TRIP = CNT_W'(MANUAL_FILT_CYC + MANUAL_DLY_CYC);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             active;
  } deb_st_t;

  deb_st_t st;
  deb_st_t next_st;

  always_comb
  begin
    next_st = st;
    // Any high sample restarts the filter, so glitches are dropped
    if (manual_reset_n_i)
    begin
      next_st.cnt    = '0; // R7
      next_st.active = 1'b0;
    end
    else if (st.cnt >= TRIP - 1'b1)
    begin
      next_st.active = 1'b1; // R8 R9
    end
    else
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st <= '0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  assign manual_active_o = st.active;

endmodule

// ---- src/supervisor_reset_watchdog.sv ----
// Purpose: Reset supervisor with supply, manual and watchdog causes
// Assumes: Analog comparators supplied as digital levels
// Notes:   All outputs are registered; reset is the power-up default
`timescale 1ns/10ps
// What this block does
// R1 - Assert reset whenever supply is below threshold, even brief dips.
// R2 - Reset asserted is the power-up and logic reset default.
// R3 - Supply recovering starts hold timer; reset stays until timer completes.
// R4 - Hold timer restarts each time the supply returns above threshold.
// R5 - Release only after supply good persists the full hold period.
// R6 - Build option selects active-low or active-high reset output.
// R7 - Manual reset input is debounced so short glitches are ignored.
// R8 - Manual low over 25 us asserts reset after about 12 us.
// R9 - Reset stays asserted while manual reset input remains low.
// R10 - After manual input returns high, hold one period then release.
// R11 - Aux fail flag low while aux sense below reference, else high.
// R12 - Aux comparison never affects the reset output.
// R13 - Low-line warning follows supplied comparator with hysteresis level.
// R14 - Each watchdog input edge clears the watchdog counter.
// R15 - Watchdog counter reaching timeout asserts reset.
// R16 - Hold period picked from four values by build parameter.
// R17 - Watchdog period picked from four values by build parameter.
// R18 - Watchdog timeout gives one hold period; counter cleared during reset.
// R19 - Condition inputs are synchronised before use.
module supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter logic       ACTIVE_HIGH = 1'b0,
  parameter logic [1:0] HOLD_SEL    = 2'h0,
  parameter logic [1:0] WDOG_SEL    = 2'h0,
  parameter logic [CNT_W-1:0] HOLD_CYC = hold_cycles(HOLD_SEL),
  parameter logic [CNT_W-1:0] WDOG_CYC = wdog_cycles(WDOG_SEL)
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  // Condition inputs
  input  wire logic supply_low_i,
  input  wire logic manual_reset_n_i,
  input  wire logic aux_sense_low_i,
  input  wire logic low_line_i,
  input  wire logic watchdog_kick_i,
  // Outputs
  output logic      cpu_reset_o,
  output logic      aux_fail_n_o,
  output logic      low_line_warn_n_o
);

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  sense_t raw;
  sense_t syn;

  always_comb
  begin
    raw                = '0;
    raw.supply_low     = supply_low_i;
    raw.manual_reset_n = manual_reset_n_i;
    raw.aux_sense_in   = aux_sense_low_i;
    raw.low_line       = low_line_i;
    raw.watchdog_kick  = watchdog_kick_i;
  end

  // Supply starts in its fault sense so reset holds; manual starts in its released (high) sense
  sync2 #(
    .INIT (1'b1)
  ) u_sync_sup (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .d_i    (raw.supply_low),
    .q_o    (syn.supply_low)
  ); // R19

  sync2 #(
    .INIT (1'b1)
  ) u_sync_man (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .d_i    (raw.manual_reset_n),
    .q_o    (syn.manual_reset_n)
  ); // R19

  // Flags start at their idle sense
  sync2 #(
    .INIT (1'b0)
  ) u_sync_aux (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .d_i    (raw.aux_sense_in),
    .q_o    (syn.aux_sense_in)
  ); // R19

  sync2 #(
    .INIT (1'b0)
  ) u_sync_ll (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .d_i    (raw.low_line),
    .q_o    (syn.low_line)
  ); // R19

  // Reset level matches the kick edge register, so no false kick
  sync2 #(
    .INIT (1'b0)
  ) u_sync_wd (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .d_i    (raw.watchdog_kick),
    .q_o    (syn.watchdog_kick)
  ); // R19

  // ------------------------------------------------------------
  // Manual reset debounce
  // ------------------------------------------------------------
  logic manual_active;

  manual_debounce u_deb (
    .clk_i            (clk_i),
    .rstn_i           (rstn_i),
    .ce_i             (ce_i),
    .manual_reset_n_i (syn.manual_reset_n),
    .manual_active_o  (manual_active)
  ); // R7 R8

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    sup_state_t       state;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] wdog_cnt;
    logic             kick_last;
    logic             rst_out;
    logic             aux_fail_n;
    logic             low_line_n;
  } top_st_t;

  top_st_t st;
  top_st_t next_st;

  // ------------------------------------------------------------
  // Causes and kick edge
  // ------------------------------------------------------------
  logic cause;
  logic kick_edge;

  always_comb
  begin
    // Aux flag is not a cause; it has no path into the reset logic
    cause     = syn.supply_low | manual_active; // R1 R9 R12
    // Either direction of the line counts as a kick
    kick_edge = syn.watchdog_kick ^ st.kick_last; // R14
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    next_st           = st;
    next_st.kick_last = syn.watchdog_kick;

    case (st.state)
      ST_HOLD:
      begin
        next_st.wdog_cnt = '0; // R18
        if (cause)
        begin
          next_st.hold_cnt = '0; // R3 R4 R10
        end
        else if (st.hold_cnt >= HOLD_CYC - 1'b1)
        begin
          next_st.state    = ST_RUN; // R5 R16
          next_st.hold_cnt = '0;
        end
        else
        begin
          next_st.hold_cnt = st.hold_cnt + 1'b1; // R3
        end
      end
      ST_RUN:
      begin
        if (cause)
        begin
          next_st.state    = ST_HOLD; // R1
          next_st.hold_cnt = '0;
          next_st.wdog_cnt = '0;
        end
        else if (kick_edge)
        begin
          next_st.wdog_cnt = '0; // R14
        end
        else if (st.wdog_cnt >= WDOG_CYC - 1'b1)
        begin
          next_st.state    = ST_HOLD; // R15 R17 R18
          next_st.wdog_cnt = '0;
          next_st.hold_cnt = '0;
        end
        else
        begin
          next_st.wdog_cnt = st.wdog_cnt + 1'b1;
        end
      end
      default:
      begin
        next_st.state = ST_HOLD;
      end
    endcase

    // Polarity applied before the register, so the pin is a bare flop
    next_st.rst_out    = (next_st.state == ST_HOLD) ? ACTIVE_HIGH : ~ACTIVE_HIGH; // R6
    next_st.aux_fail_n = ~syn.aux_sense_in; // R11
    // Hysteresis lives in the analog comparator feeding this level
    next_st.low_line_n = ~syn.low_line; // R13
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st.state      <= ST_HOLD; // R2
      st.hold_cnt   <= '0;
      st.wdog_cnt   <= '0;
      st.kick_last  <= 1'b0;
      st.rst_out    <= ACTIVE_HIGH; // R2 R6
      st.aux_fail_n <= FLAG_IDLE;
      st.low_line_n <= FLAG_IDLE;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign cpu_reset_o       = st.rst_out; // R6
  assign aux_fail_n_o      = st.aux_fail_n;
  assign low_line_warn_n_o = st.low_line_n;

endmodule

// ---- bench/supervisor_reset_watchdog_chk.sv ----
// Purpose: Port assertions for the supervisor
// Assumes: ce_i low pauses every check but the reset one
// Notes:   Cause counters give the bounds
`timescale 1ns/10ps
module supervisor_reset_watchdog_chk
  import supervisor_pkg::*;
#(
  parameter logic             ACTIVE_HIGH = 1'b0,
  parameter logic [CNT_W-1:0] HOLD_CYC    = 32'h32,
  parameter logic [CNT_W-1:0] WDOG_CYC    = 32'hc8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Conditions
  input wire logic supply_low_i,
  input wire logic manual_reset_n_i,
  input wire logic aux_sense_low_i,
  input wire logic low_line_i,
  input wire logic watchdog_kick_i,
  // Outputs
  input wire logic cpu_reset_o,
  input wire logic aux_fail_n_o,
  input wire logic low_line_warn_n_o
);
  logic        asserted;
  logic [31:0] quiet;
  logic [31:0] sq;
  logic [31:0] mlow;
  logic [31:0] kq;
  assign asserted = (cpu_reset_o == ACTIVE_HIGH);
  // ----
  // Cause counters
  // ----
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      quiet <= 32'h0;
      sq    <= 32'h0;
      mlow  <= 32'h0;
      kq    <= 32'h0;
    end
    else
    begin
      quiet <= (supply_low_i || !manual_reset_n_i) ? 32'h0 : quiet + 32'h1;
      sq    <= supply_low_i ? 32'h0 : sq + 32'h1;
      mlow  <= manual_reset_n_i ? 32'h0 : mlow + 32'h1;
      kq    <= (asserted || $changed(watchdog_kick_i)) ? 32'h0 : kq + 32'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i || !ce_i);
  sequence aux_steady_s;
    $stable(aux_sense_low_i) [*3];
  endsequence
  sequence line_steady_s;
    $stable(low_line_i) [*3];
  endsequence
  reset_default_a: assert property (disable iff (1'b0) !rstn_i |=> asserted && aux_fail_n_o && low_line_warn_n_o)
    else $error("outputs not at reset level");
  supply_trip_a: assert property (supply_low_i |-> ##5 asserted)
    else $error("supply dip missed");
  aux_flag_a: assert property (aux_steady_s |=> aux_fail_n_o != $past(aux_sense_low_i))
    else $error("aux flag wrong");
  line_warn_a: assert property (line_steady_s |=> low_line_warn_n_o != $past(low_line_i))
    else $error("low line flag wrong");
  release_hold_a: assert property ($fell(asserted) |-> quiet >= HOLD_CYC)
    else $error("reset released early");
  rise_cause_a: assert property ($rose(asserted) |-> sq < 8 || mlow > 4600 || kq >= WDOG_CYC - 4)
    else $error("reset without cause");
  manual_hold_a: assert property (mlow > 4700 |-> asserted)
    else $error("manual reset not held");
  wdog_fire_a: assert property (kq == WDOG_CYC + 8 |-> asserted)
    else $error("watchdog did not fire");
endmodule
bind supervisor_reset_watchdog supervisor_reset_watchdog_chk #(
  .ACTIVE_HIGH(ACTIVE_HIGH), .HOLD_CYC(HOLD_CYC), .WDOG_CYC(WDOG_CYC)
) i_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .supply_low_i(supply_low_i),
  .manual_reset_n_i(manual_reset_n_i), .aux_sense_low_i(aux_sense_low_i),
  .low_line_i(low_line_i), .watchdog_kick_i(watchdog_kick_i), .cpu_reset_o(cpu_reset_o),
  .aux_fail_n_o(aux_fail_n_o), .low_line_warn_n_o(low_line_warn_n_o)
);

// ---- bench/cpu_model.sv ----
// Purpose: Processor that kicks the watchdog
// Assumes: Kick gap below the watchdog period
// Notes:   Runs no code while held in reset
`timescale 1ns/10ps
module cpu_model
(
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       in_reset_i,
  input  wire logic       kick_en_i,
  input  wire logic [7:0] period_i,
  // Watchdog line
  output logic            kick_o
);
  logic [7:0] cnt;
  initial
  begin
    cnt = 8'h00;
    kick_o = 1'b0;
  end
  always @(posedge clk_i)
  begin
    if (in_reset_i || !kick_en_i)
      cnt <= 8'h00;
    else if (cnt >= period_i)
    begin
      cnt <= 8'h00;
      kick_o <= ~kick_o;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule

// ---- bench/supervisor_reset_watchdog_tb.sv ----
// Purpose: Self-checking bench for the supervisor
// Assumes: Short hold and watchdog counts
// Notes:   Both polarity variants are built on the same stimulus
`timescale 1ns/10ps
module supervisor_reset_watchdog_tb;
  import supervisor_pkg::*;
  localparam logic ACT = 1'b0;
  logic       clk_i;
  logic       rstn_i;
  logic       ce;
  logic       reset_hi;
  logic       supply_low_i;
  logic       manual_reset_n_i;
  logic       aux_sense_low_i;
  logic       low_line_i;
  logic       kick_en;
  logic       kick;
  logic [7:0] period;
  logic       cpu_reset_o;
  logic       aux_fail_n_o;
  logic       low_line_warn_n_o;
  int         failures;
  int         comparisons;
  int         seed;
  int         i;
  supervisor_reset_watchdog #(
    .ACTIVE_HIGH(ACT), .HOLD_CYC(32'h32), .WDOG_CYC(32'hc8)
  ) i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .supply_low_i(supply_low_i),
    .manual_reset_n_i(manual_reset_n_i), .aux_sense_low_i(aux_sense_low_i), .low_line_i(low_line_i),
    .watchdog_kick_i(kick), .cpu_reset_o(cpu_reset_o), .aux_fail_n_o(aux_fail_n_o),
    .low_line_warn_n_o(low_line_warn_n_o)
  );
  supervisor_reset_watchdog #(
    .ACTIVE_HIGH(1'b1), .HOLD_CYC(32'h32), .WDOG_CYC(32'hc8)
  ) i_dut_hi (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .supply_low_i(supply_low_i),
    .manual_reset_n_i(manual_reset_n_i), .aux_sense_low_i(aux_sense_low_i), .low_line_i(low_line_i),
    .watchdog_kick_i(kick), .cpu_reset_o(reset_hi), .aux_fail_n_o(), .low_line_warn_n_o()
  );
  cpu_model i_cpu (
    .clk_i(clk_i), .in_reset_i(cpu_reset_o == ACT), .kick_en_i(kick_en), .period_i(period), .kick_o(kick)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic rst_lvl(input logic on);
    return on ? ACT : !ACT;
  endfunction
  task automatic chk(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial
  begin
    seed = 88;
    failures = 0;
    comparisons = 0;
    rstn_i = 1'b0;
    ce = 1'b1;
    supply_low_i = 1'b0;
    manual_reset_n_i = 1'b1;
    aux_sense_low_i = 1'b0;
    low_line_i = 1'b0;
    kick_en = 1'b1;
    period = 8'h28;
    wt(8);
    chk(cpu_reset_o, rst_lvl(1));
    chk(aux_fail_n_o, 1'b1);
    chk(reset_hi, !rst_lvl(1));
    rstn_i = 1'b1;
    wt(40);
    chk(cpu_reset_o, rst_lvl(1));
    wt(30);
    chk(cpu_reset_o, rst_lvl(0));
    chk(reset_hi, !rst_lvl(0));
    for (i = 0; i < 6; i++)
    begin
      wt(10 + $unsigned($random(seed)) % 30);
      supply_low_i = 1'b1;
      wt(1);
      supply_low_i = 1'b0;
      wt(6);
      chk(cpu_reset_o, rst_lvl(1));
    end
    wt(40);
    chk(cpu_reset_o, rst_lvl(1));
    wt(25);
    chk(cpu_reset_o, rst_lvl(0));
    for (i = 0; i < 24; i++)
    begin
      aux_sense_low_i = 1'($random(seed));
      low_line_i = 1'($random(seed));
      wt(4);
      chk(aux_fail_n_o, !aux_sense_low_i);
      chk(low_line_warn_n_o, !low_line_i);
      chk(cpu_reset_o, rst_lvl(0));
    end
    // Clock enable low freezes the flag even as its input moves
    ce = 1'b0;
    aux_sense_low_i = !aux_sense_low_i;
    wt(8);
    chk(aux_fail_n_o, aux_sense_low_i);
    ce = 1'b1;
    wt(4);
    chk(aux_fail_n_o, !aux_sense_low_i);
    manual_reset_n_i = 1'b0;
    wt(100);
    manual_reset_n_i = 1'b1;
    wt(10);
    chk(cpu_reset_o, rst_lvl(0));
    manual_reset_n_i = 1'b0;
    wt(3100);
    chk(cpu_reset_o, rst_lvl(0));
    wt(1560);
    chk(cpu_reset_o, rst_lvl(1));
    chk(reset_hi, !rst_lvl(1));
    wt(500);
    chk(cpu_reset_o, rst_lvl(1));
    manual_reset_n_i = 1'b1;
    wt(40);
    chk(cpu_reset_o, rst_lvl(1));
    wt(25);
    chk(cpu_reset_o, rst_lvl(0));
    for (i = 0; i < 8; i++)
    begin
      period = 8'(20 + $unsigned($random(seed)) % 120);
      wt(150);
      chk(cpu_reset_o, rst_lvl(0));
    end
    @(kick);
    #1;
    kick_en = 1'b0;
    wt(190);
    chk(cpu_reset_o, rst_lvl(0));
    wt(25);
    chk(cpu_reset_o, rst_lvl(1));
    wt(30);
    chk(cpu_reset_o, rst_lvl(1));
    wt(30);
    chk(cpu_reset_o, rst_lvl(0));
    wt(150);
    chk(cpu_reset_o, rst_lvl(0));
    wt(50);
    chk(cpu_reset_o, rst_lvl(1));
    rstn_i = 1'b0;
    wt(2);
    chk(cpu_reset_o, rst_lvl(1));
    chk(low_line_warn_n_o, 1'b1);
    finish_test();
  end
  // Hang guard well past the planned run
  initial
  begin
    #400000;
    failures++;
    finish_test();
  end
endmodule
